// >>> pkg/opmode_pkg.sv
package opmode_pkg;
	typedef enum logic [1:0] {MODE_EXT, MODE_PANEL, MODE_NET, MODE_COMB} mode_e;

	// Register byte offsets
	localparam logic [7:0]  ADDR_SETTINGS    = 8'h00;
	localparam logic [7:0]  ADDR_MODE_REQ    = 8'h04;
	localparam logic [7:0]  ADDR_STATUS      = 8'h08;

	// Field positions
	localparam int unsigned MS_LSB           = 0;
	localparam int unsigned MS_W             = 3;
	localparam int unsigned SM_LSB           = 8;
	localparam int unsigned SM_W             = 4;
	localparam int unsigned EXT_BIT          = 16;
	localparam int unsigned REQ_LSB          = 0;
	localparam int unsigned STAT_MODE_LSB    = 0;
	localparam int unsigned STAT_REFUSED_BIT = 4;
	localparam int unsigned STAT_RUN_BIT     = 8;
	localparam int unsigned STAT_STOP_BIT    = 9;

	// Mode select values
	localparam logic [2:0]  MS_EXT_FIRST     = 3'h0;
	localparam logic [2:0]  MS_PANEL_FIXED   = 3'h1;
	localparam logic [2:0]  MS_EXT_NET       = 3'h2;
	localparam logic [2:0]  MS_COMB1         = 3'h3;
	localparam logic [2:0]  MS_COMB2         = 3'h4;
	localparam logic [2:0]  MS_RUN_SWITCH    = 3'h6;
	localparam logic [2:0]  MS_STOP_GATED    = 3'h7;

	// Startup mode values
	localparam logic [3:0]  SM_AS_SET        = 4'h0;
	localparam logic [3:0]  SM_NET           = 4'h1;
	localparam logic [3:0]  SM_PANEL_NET     = 4'hA;

	// Reset values and the extended-enable level
	localparam logic [2:0]  MS_RESET         = 3'h0;
	localparam logic [3:0]  SM_RESET         = 4'h0;
	localparam logic        EXT_RESET        = 1'h0;
	localparam logic        EXT_ENABLED      = 1'h0;
endpackage : opmode_pkg

// >>> design/opmode_select.sv
// The APB slave port and the address map were left to the implementer.
module opmode_select (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Drive status and panel inputs
	input  wire logic        I_MOTOR_RUN,
	input  wire logic        I_OUTPUT_STOP,
	input  wire logic        I_PANEL_KEY,
	input  wire logic        I_PANEL_NET_TOGGLE,
	input  wire logic        I_RESTART,
	// Operation mode
	output logic      [1:0]  O_MODE
);
	logic [2:0]          ms_q;
	logic [2:0]          ms_d;
	logic [3:0]          sm_q;
	logic [3:0]          sm_d;
	logic                ext_q;
	logic                ext_d;
	logic                start_q;
	logic                start_d;
	logic                refused_q;
	logic                refused_d;
	opmode_pkg::mode_e   mode_q;
	opmode_pkg::mode_e   mode_d;
	logic                pready_q;
	logic                pready_d;
	logic                pslverr_q;
	logic                pslverr_d;
	logic [31:0]         prdata_q;
	logic [31:0]         prdata_d;
	logic                access;
	logic                done;
	logic                wr_settings;
	logic                wr_req;
	logic                wr_status;
	logic                mapped;
	logic [31:0]         rdata;
	logic                pn_sel;
	logic                req_valid;
	opmode_pkg::mode_e   req_tgt;
	opmode_pkg::mode_e   key_tgt;
	opmode_pkg::mode_e   start_sel;
	logic                grant;
	logic [2:0]          wr_ms;
	logic [3:0]          wr_sm;

	function automatic opmode_pkg::mode_e start_mode(input logic [2:0] ms, input logic [3:0] sm,
		input logic stop);
		opmode_pkg::mode_e m;
		m = opmode_pkg::MODE_EXT;
		case (ms)
			opmode_pkg::MS_PANEL_FIXED: m = opmode_pkg::MODE_PANEL;
			opmode_pkg::MS_COMB1,
			opmode_pkg::MS_COMB2: m = opmode_pkg::MODE_COMB;
			opmode_pkg::MS_STOP_GATED: m = (sm == opmode_pkg::SM_NET && stop) ? opmode_pkg::MODE_NET
				: opmode_pkg::MODE_EXT;
			// external unless startup asks network; network start
			default: m = (sm == opmode_pkg::SM_AS_SET) ? opmode_pkg::MODE_EXT : opmode_pkg::MODE_NET;
		endcase
		return m;
	endfunction : start_mode

	function automatic logic allowed(input opmode_pkg::mode_e cur, input opmode_pkg::mode_e tgt,
		input logic [2:0] ms, input logic pn, input logic run, input logic stop);
		logic ok;
		logic direct;
		ok = 1'b0;
		direct = (cur != opmode_pkg::MODE_EXT) && (tgt != opmode_pkg::MODE_EXT);
		if (tgt == cur || tgt == opmode_pkg::MODE_COMB || cur == opmode_pkg::MODE_COMB) begin
			ok = 1'b0;
		// select 6 allows switching while running; likewise
		end else if (run && ms != opmode_pkg::MS_RUN_SWITCH) begin
			ok = 1'b0;
		end else if (pn) begin
			ok = (ms != opmode_pkg::MS_EXT_NET) && direct;
		end else begin
			case (ms)
				opmode_pkg::MS_EXT_FIRST,
				opmode_pkg::MS_RUN_SWITCH: ok = !direct;
				opmode_pkg::MS_EXT_NET: ok = (cur != opmode_pkg::MODE_PANEL) && (tgt != opmode_pkg::MODE_PANEL);
				opmode_pkg::MS_STOP_GATED: ok = stop && !direct;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : allowed

	// APB decode; slave answers in the second access cycle
	always_comb begin
		access      = I_PSEL && I_PENABLE;
		done        = access && pready_q;
		mapped      = (I_PADDR == opmode_pkg::ADDR_SETTINGS) || (I_PADDR == opmode_pkg::ADDR_MODE_REQ)
			|| (I_PADDR == opmode_pkg::ADDR_STATUS);
		wr_settings = done && I_PWRITE && (I_PADDR == opmode_pkg::ADDR_SETTINGS);
		wr_req      = done && I_PWRITE && (I_PADDR == opmode_pkg::ADDR_MODE_REQ);
		wr_status   = done && I_PWRITE && (I_PADDR == opmode_pkg::ADDR_STATUS);
		wr_ms       = I_PWDATA[opmode_pkg::MS_LSB +: opmode_pkg::MS_W];
		wr_sm       = I_PWDATA[opmode_pkg::SM_LSB +: opmode_pkg::SM_W];
		rdata       = 32'h0;
		case (I_PADDR)
			opmode_pkg::ADDR_SETTINGS: begin
				rdata[opmode_pkg::MS_LSB +: opmode_pkg::MS_W] = ms_q;
				rdata[opmode_pkg::SM_LSB +: opmode_pkg::SM_W] = sm_q;
				rdata[opmode_pkg::EXT_BIT]                    = ext_q;
			end
			opmode_pkg::ADDR_STATUS: begin
				rdata[opmode_pkg::STAT_MODE_LSB +: 2]         = mode_q;
				rdata[opmode_pkg::STAT_REFUSED_BIT]           = refused_q;
				rdata[opmode_pkg::STAT_RUN_BIT]               = I_MOTOR_RUN;
				rdata[opmode_pkg::STAT_STOP_BIT]              = I_OUTPUT_STOP;
			end
			default: rdata = 32'h0;
		endcase
		pready_d  = access && !pready_q;
		pslverr_d = access && !pready_q && !mapped;
		prdata_d  = (access && !pready_q && !I_PWRITE) ? rdata : 32'h0;
	end

	// Settings storage
	always_comb begin
		ms_d  = ms_q;
		sm_d  = sm_q;
		ext_d = ext_q;
		if (wr_settings) begin
			ext_d = I_PWDATA[opmode_pkg::EXT_BIT];
			if (!I_MOTOR_RUN) begin
				if (wr_ms <= opmode_pkg::MS_COMB2 || wr_ms == opmode_pkg::MS_RUN_SWITCH
					|| wr_ms == opmode_pkg::MS_STOP_GATED) begin
					ms_d = wr_ms;
				end
				// locked unless extended enable is zero
				if (ext_q == opmode_pkg::EXT_ENABLED && (wr_sm == opmode_pkg::SM_AS_SET
					|| wr_sm == opmode_pkg::SM_NET || wr_sm == opmode_pkg::SM_PANEL_NET)) begin
					sm_d = wr_sm;
				end
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ms_q  <= opmode_pkg::MS_RESET;
			sm_q  <= opmode_pkg::SM_RESET;
			ext_q <= opmode_pkg::EXT_RESET;
		end else begin
			ms_q  <= ms_d;
			sm_q  <= sm_d;
			ext_q <= ext_d;
		end
	end

	// Mode selection and switching
	always_comb begin
		pn_sel    = (sm_q == opmode_pkg::SM_PANEL_NET) && (ms_q == opmode_pkg::MS_EXT_FIRST
			|| ms_q == opmode_pkg::MS_EXT_NET || ms_q == opmode_pkg::MS_RUN_SWITCH);
		start_sel = start_mode(ms_q, sm_q, I_OUTPUT_STOP);
		key_tgt   = (mode_q == opmode_pkg::MODE_PANEL)
			? (pn_sel ? opmode_pkg::MODE_NET : opmode_pkg::MODE_EXT) : opmode_pkg::MODE_PANEL;
		req_valid = 1'b0;
		req_tgt   = mode_q;
		if (wr_req) begin
			req_valid = 1'b1;
			req_tgt   = opmode_pkg::mode_e'(I_PWDATA[opmode_pkg::REQ_LSB +: 2]);
		end else if (I_PANEL_KEY || (I_PANEL_NET_TOGGLE && pn_sel)) begin
			// key or toggle flips panel and network when pn_sel is set; otherwise key flips panel and external
			req_valid = 1'b1;
			req_tgt   = key_tgt;
		end
		grant     = req_valid && allowed(mode_q, req_tgt, ms_q, pn_sel, I_MOTOR_RUN, I_OUTPUT_STOP);
		start_d   = I_RESTART;
		mode_d    = mode_q;
		refused_d = refused_q;
		if (wr_status && I_PWDATA[opmode_pkg::STAT_REFUSED_BIT]) begin
			refused_d = 1'b0;
		end
		if (start_q) begin
			// same decision after every reset; evaluated again the cycle after each I_RESTART pulse
			mode_d = start_sel;
		end else if (ms_q == opmode_pkg::MS_STOP_GATED && !I_OUTPUT_STOP) begin
			mode_d = opmode_pkg::MODE_EXT;
		end else if (grant) begin
			mode_d = req_tgt;
		end else if (req_valid) begin
			// Set wins over a clear in the same cycle
			refused_d = 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			start_q   <= 1'b1;
			mode_q    <= opmode_pkg::MODE_EXT;
			refused_q <= 1'b0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			start_q   <= start_d;
			mode_q    <= mode_d;
			refused_q <= refused_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	always_comb begin
		O_PRDATA  = prdata_q;
		O_PREADY  = pready_q;
		O_PSLVERR = pslverr_q;
		O_MODE    = mode_q;
	end

	AST_STARTUP_MODE: assert property (@(posedge I_CLK) disable iff (I_RST)
		start_q |=> mode_q == $past(start_sel))
		else $error("startup mode differs from settings");

	AST_PANEL_FIXED: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && ms_q == opmode_pkg::MS_PANEL_FIXED && mode_q == opmode_pkg::MODE_PANEL)
		|=> mode_q == opmode_pkg::MODE_PANEL)
		else $error("panel mode left while fixed");

	AST_COMB_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && mode_q == opmode_pkg::MODE_COMB && ms_q != opmode_pkg::MS_STOP_GATED)
		|=> mode_q == opmode_pkg::MODE_COMB)
		else $error("combined mode left");

	AST_NO_PANEL_EXTNET: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && ms_q == opmode_pkg::MS_EXT_NET && mode_q != opmode_pkg::MODE_PANEL)
		|=> mode_q != opmode_pkg::MODE_PANEL)
		else $error("panel entered under select 2");

	AST_STOP_FORCE: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && ms_q == opmode_pkg::MS_STOP_GATED && !I_OUTPUT_STOP)
		|=> mode_q == opmode_pkg::MODE_EXT)
		else $error("external mode not forced");

	AST_NO_DIRECT: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && !pn_sel && mode_q != opmode_pkg::MODE_EXT)
		|=> (mode_q == $past(mode_q) || mode_q == opmode_pkg::MODE_EXT))
		else $error("direct panel-network switch");

	AST_TOGGLE_SWITCH: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && pn_sel && ms_q != opmode_pkg::MS_EXT_NET && !wr_req && I_PANEL_NET_TOGGLE
		&& (!I_MOTOR_RUN || ms_q == opmode_pkg::MS_RUN_SWITCH) && mode_q == opmode_pkg::MODE_PANEL)
		|=> mode_q == opmode_pkg::MODE_NET)
		else $error("toggle did not switch to network");

	AST_NET_FIXED: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!start_q && sm_q == opmode_pkg::SM_PANEL_NET && ms_q == opmode_pkg::MS_EXT_NET)
		|=> mode_q == $past(mode_q))
		else $error("mode changed under fixed network");

	AST_SM_LOCK: assert property (@(posedge I_CLK) disable iff (I_RST)
		(wr_settings && ext_q != opmode_pkg::EXT_ENABLED) |=> sm_q == $past(sm_q))
		else $error("startup setting written while locked");

	AST_STOPPED_ONLY: assert property (@(posedge I_CLK) disable iff (I_RST)
		(wr_settings && I_MOTOR_RUN) |=> (ms_q == $past(ms_q) && sm_q == $past(sm_q)))
		else $error("settings written while running");
endmodule : opmode_select

// >>> dv/panel_terminal_model.sv
module panel_terminal_model (
	// Clock
	input  wire logic I_CLK,
	// Panel key and terminal lines
	output logic      o_key,
	output logic      o_toggle,
	output logic      o_stop,
	output logic      o_run
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_key = 1'b0;
		o_toggle = 1'b0;
		o_stop = 1'b0;
		o_run = 1'b0;
	end

	task automatic press(input logic tgl);
		@(posedge I_CLK);
		if (tgl) begin
			o_toggle <= 1'b1;
		end else begin
			o_key <= 1'b1;
		end
		@(posedge I_CLK);
		o_key <= 1'b0;
		o_toggle <= 1'b0;
	endtask : press

	// Levels move only between presses so a press never sees a half-changed state
	task automatic levels(input logic stop, input logic run);
		@(posedge I_CLK);
		o_stop <= stop;
		o_run <= run;
	endtask : levels
endmodule : panel_terminal_model

// >>> dv/startup_operation_mode_select_tb.sv
module startup_operation_mode_select_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, psel, penable, pwrite, restart, pready, pslverr, err;
	logic        key, toggle, stop, run;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  mode;
	logic [2:0]  ms_tab [6];
	logic [1:0]  md_tab [6];
	int          n_errors, total_checks;

	opmode_select u_dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_MOTOR_RUN(run), .I_OUTPUT_STOP(stop), .I_PANEL_KEY(key), .I_PANEL_NET_TOGGLE(toggle),
		.I_RESTART(restart), .O_MODE(mode));
	panel_terminal_model u_pm (.I_CLK(clk), .o_key(key), .o_toggle(toggle), .o_stop(stop), .o_run(run));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Sample at the rising edge itself: this is the edge at which the slave takes the transfer
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		check(32'(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			summarize();
		end
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd & mask, exp);
	endtask : rd_chk

	task automatic mchk(input logic [1:0] exp);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(32'(mode), 32'(exp));
	endtask : mchk

	task automatic press(input logic tgl, input logic [1:0] exp);
		u_pm.press(tgl);
		mchk(exp);
	endtask : press

	task automatic req(input logic [1:0] tgt, input logic [1:0] exp);
		apb(1'b1, opmode_pkg::ADDR_MODE_REQ, 32'(tgt));
		mchk(exp);
	endtask : req

	task automatic boot(input logic [2:0] ms, input logic [3:0] sm, input logic [1:0] exp);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, {20'h0, sm, 5'h0, ms});
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		mchk(exp);
	endtask : boot

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		restart = 1'b0;
		n_errors = 0;
		total_checks = 0;
		ms_tab = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
		md_tab = '{opmode_pkg::MODE_NET, opmode_pkg::MODE_PANEL, opmode_pkg::MODE_NET, opmode_pkg::MODE_COMB,
			opmode_pkg::MODE_COMB, opmode_pkg::MODE_NET};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		mchk(opmode_pkg::MODE_EXT);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0001_0F07, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		check(32'(err), 32'h1);
		press(1'b0, opmode_pkg::MODE_PANEL);
		press(1'b0, opmode_pkg::MODE_EXT);
		req(opmode_pkg::MODE_NET, opmode_pkg::MODE_NET);
		req(opmode_pkg::MODE_EXT, opmode_pkg::MODE_EXT);
		press(1'b0, opmode_pkg::MODE_PANEL);
		req(opmode_pkg::MODE_NET, opmode_pkg::MODE_PANEL);
		rd_chk(opmode_pkg::ADDR_STATUS, 32'h13, 32'h11);
		apb(1'b1, opmode_pkg::ADDR_STATUS, 32'h10);
		rd_chk(opmode_pkg::ADDR_STATUS, 32'h10, 32'h0);
		press(1'b0, opmode_pkg::MODE_EXT);
		u_pm.levels(1'b0, 1'b1);
		req(opmode_pkg::MODE_PANEL, opmode_pkg::MODE_EXT);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, 32'h0000_0101);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0000_0F07, 32'h0);
		u_pm.levels(1'b0, 1'b0);
		boot(3'h1, 4'h0, opmode_pkg::MODE_PANEL);
		press(1'b0, opmode_pkg::MODE_PANEL);
		req(opmode_pkg::MODE_EXT, opmode_pkg::MODE_PANEL);
		boot(3'h2, 4'h0, opmode_pkg::MODE_EXT);
		req(opmode_pkg::MODE_PANEL, opmode_pkg::MODE_EXT);
		req(opmode_pkg::MODE_NET, opmode_pkg::MODE_NET);
		boot(3'h3, 4'h0, opmode_pkg::MODE_COMB);
		press(1'b0, opmode_pkg::MODE_COMB);
		boot(3'h4, 4'h0, opmode_pkg::MODE_COMB);
		req(opmode_pkg::MODE_EXT, opmode_pkg::MODE_COMB);
		boot(3'h6, 4'h0, opmode_pkg::MODE_EXT);
		u_pm.levels(1'b0, 1'b1);
		press(1'b0, opmode_pkg::MODE_PANEL);
		u_pm.levels(1'b0, 1'b0);
		boot(3'h7, 4'h0, opmode_pkg::MODE_EXT);
		press(1'b0, opmode_pkg::MODE_EXT);
		u_pm.levels(1'b1, 1'b0);
		press(1'b0, opmode_pkg::MODE_PANEL);
		u_pm.levels(1'b0, 1'b0);
		mchk(opmode_pkg::MODE_EXT);
		for (int i = 0; i < 6; i++) begin
			boot(ms_tab[i], 4'h1, md_tab[i]);
		end
		u_pm.levels(1'b1, 1'b0);
		boot(3'h7, 4'h1, opmode_pkg::MODE_NET);
		u_pm.levels(1'b0, 1'b0);
		boot(3'h7, 4'h1, opmode_pkg::MODE_EXT);
		boot(3'h0, 4'hA, opmode_pkg::MODE_NET);
		press(1'b1, opmode_pkg::MODE_PANEL);
		press(1'b0, opmode_pkg::MODE_NET);
		req(opmode_pkg::MODE_EXT, opmode_pkg::MODE_NET);
		boot(3'h6, 4'hA, opmode_pkg::MODE_NET);
		u_pm.levels(1'b0, 1'b1);
		press(1'b1, opmode_pkg::MODE_PANEL);
		u_pm.levels(1'b0, 1'b0);
		boot(3'h2, 4'hA, opmode_pkg::MODE_NET);
		press(1'b0, opmode_pkg::MODE_NET);
		press(1'b1, opmode_pkg::MODE_NET);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, 32'h0001_0A02);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, 32'h0001_0102);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0001_0F00, 32'h0001_0A00);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, 32'h0000_0102);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0001_0F00, 32'h0000_0A00);
		apb(1'b1, opmode_pkg::ADDR_SETTINGS, 32'h0000_0102);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0001_0F00, 32'h0000_0100);
		boot(3'h1, 4'h0, opmode_pkg::MODE_PANEL);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		mchk(opmode_pkg::MODE_EXT);
		rd_chk(opmode_pkg::ADDR_SETTINGS, 32'h0001_0F07, 32'h0);
		summarize();
	end
endmodule : startup_operation_mode_select_tb
